// ==== sysctl_pkg.sv ====
package sysctl_pkg;

  // Interrupt source bit positions
  localparam int IRQ_COUNT = 4;
  localparam int MAIN_OSC_POWERUP_IRQ = 0;
  localparam int USB_SYNTH_LOCK_IRQ = 1;
  localparam int MAIN_SYNTH_LOCK_IRQ = 2;
  localparam int BROWNOUT_IRQ = 3;

  // Regulator codes: 0 is 2.25 V, each step 50 mV, 10 is 2.75 V
  localparam int VCODE_W = 4;
  localparam logic [3:0] VCODE_MIN = 4'h0;
  localparam logic [3:0] VCODE_MAX = 4'hA;
  localparam logic [3:0] VCODE_RESET = 4'h5;

  // Gated peripherals: adc, 3 comp, 8 gpio, hib, 2 i2c, pwm, qei,
  // 2 ssi, 4 timer, 3 uart, dma, usb, wdog
  localparam int PERIPH_COUNT = 29;
  localparam logic [4:0] PERIPH_SEL_MAX = 5'h1C;

  // Software access strobes and data, one group
  typedef struct packed {
    logic irq_enable_set;
    logic irq_enable_clr;
    logic irq_clear;
    logic [IRQ_COUNT-1:0] irq_source_mask;
  } irq_cmd_s;

endpackage

// ==== periph_gate.sv ====
`timescale 1ns/1ps
`default_nettype none
// One peripheral's clock gate decision, held per peripheral
module periph_gate (
  input wire logic i_mclk, // System clock
  input wire logic i_rst_n, // Synchronised reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic i_ds_set, // Set deep-sleep enable
  input wire logic i_ds_clr, // Clear deep-sleep enable
  input wire logic i_run_en, // Run-mode enable
  input wire logic i_gating_on, // Sleep gating active
  input wire logic i_deep_sleep, // Processor in deep-sleep
  output logic o_ds_en, // Held deep-sleep enable
  output logic o_clk_en // Next clock enable
);
  logic ds_en;
  logic next_ds_en;

  // Enable bit is retained whatever the gating mode
  always_comb begin
    next_ds_en = ds_en;
    if (i_ds_set) begin
      next_ds_en = 1'b1;
    end else if (i_ds_clr) begin
      next_ds_en = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ds_en <= 1'b0;
    end else if (i_ce) begin
      ds_en <= next_ds_en;
    end
  end

  assign o_ds_en = ds_en;
  // Stopped when run enable is clear, or in deep-sleep with gating on and enable clear
  assign o_clk_en = i_run_en & ~(i_gating_on & i_deep_sleep & ~ds_en); // [RL12] [RL13] [RL14]
endmodule // periph_gate
`default_nettype wire

// ==== sysctl_irq_and_sleep_gating.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RL1] Four interrupt sources share one mask
// [RL2] Clearing a source drops its request
// [RL3] Only enabled sources reach processor interrupt
// [RL4] Set any enable bits, others unchanged
// [RL5] Clear any enable bits, others unchanged
// [RL6] Raw and masked status views readable
// [RL7] Software should clear source early
// [RL8] Regulator code 2.25 V to 2.75 V, 50 mV
// [RL9] Regulator resets to 2.5 V
// [RL10] Reading regulator returns held code
// [RL11] Gating off: sleep clocks like run
// [RL12] Gating on: deep-sleep stops disabled clocks
// [RL13] Stopped peripheral resumes on deep-sleep exit
// [RL14] Deep-sleep enables retained while gating off
// [RL15] Separate enable for each listed peripheral
// [RL16] Clear is write-one-to-clear
// [RL17] Raw latches, masked is AND, irq is OR
module sysctl_irq_and_sleep_gating
  import sysctl_pkg::*;
#(
  parameter int NUM_PERIPH = PERIPH_COUNT
) (
  input wire logic i_mclk, // 10 MHz system clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_ce, // Clock enable, freezes state when low
  input wire logic [IRQ_COUNT-1:0] i_irq_event, // Source event pins
  input wire irq_cmd_s i_irq_cmd, // Enable/clear accesses
  input wire logic i_masked_view_select, // 1 selects masked status
  input wire logic i_vcode_write, // Regulator code write strobe
  input wire logic [VCODE_W-1:0] i_regulator_voltage_code, // Code written
  input wire logic i_gating_write, // Gating mode write strobe
  input wire logic i_sleep_gating_on, // Gating mode written
  input wire logic i_ds_enable, // Deep-sleep enable set strobe
  input wire logic i_ds_disable, // Deep-sleep enable clear strobe
  input wire logic [4:0] i_peripheral_select, // Peripheral index
  input wire logic [NUM_PERIPH-1:0] i_run_enable, // Run-mode enables
  input wire logic i_deep_sleep, // Processor in deep-sleep
  output logic o_irq, // Processor interrupt request
  output logic [IRQ_COUNT-1:0] o_irq_status, // Selected status view
  output logic [VCODE_W-1:0] o_regulator_voltage_code, // Held code
  output logic o_sleep_gating_on, // Gating mode
  output logic [NUM_PERIPH-1:0] o_ds_enable, // Held deep-sleep enables
  output logic [NUM_PERIPH-1:0] o_periph_clk_en // Peripheral clock enables
);

  // Refuse peripheral counts that the 5-bit select cannot reach
  if (NUM_PERIPH < 1 || NUM_PERIPH > 32) begin : gen_bad_count
    $error("NUM_PERIPH out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset release and event pin synchronisers
  logic [1:0] rst_sync;
  logic rst_n;
  logic [IRQ_COUNT-1:0] ev_meta;
  logic [IRQ_COUNT-1:0] ev_sync;
  logic [IRQ_COUNT-1:0] ev_prev;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ev_meta <= '0;
      ev_sync <= '0;
      ev_prev <= '0;
    end else if (i_ce) begin
      ev_meta <= i_irq_event;
      ev_sync <= ev_meta;
      ev_prev <= ev_sync;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt state
  logic [IRQ_COUNT-1:0] raw;
  logic [IRQ_COUNT-1:0] enable;
  logic [IRQ_COUNT-1:0] next_raw;
  logic [IRQ_COUNT-1:0] next_enable;
  logic [IRQ_COUNT-1:0] ev_pulse;
  logic [IRQ_COUNT-1:0] next_masked;
  logic next_irq;
  logic [IRQ_COUNT-1:0] next_status;

  // Latch events, clears, enable set/clear and views
  always_comb begin
    ev_pulse = ev_sync & ~ev_prev; // [RL1]
    next_raw = raw;
    if (i_irq_cmd.irq_clear) begin
      next_raw = raw & ~i_irq_cmd.irq_source_mask; // [RL2] [RL16]
    end
    next_raw = next_raw | ev_pulse; // Set wins over clear [RL17]
    next_enable = enable;
    if (i_irq_cmd.irq_enable_set) begin
      next_enable = next_enable | i_irq_cmd.irq_source_mask; // [RL4]
    end
    if (i_irq_cmd.irq_enable_clr) begin
      next_enable = next_enable & ~i_irq_cmd.irq_source_mask; // [RL5]
    end
    next_masked = next_raw & next_enable; // [RL3] [RL17]
    next_irq = |next_masked; // [RL3] [RL17]
    next_status = i_masked_view_select ? next_masked : next_raw; // [RL6]
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      raw <= '0;
      enable <= '0;
      o_irq <= 1'b0;
      o_irq_status <= '0;
    end else if (i_ce) begin
      raw <= next_raw;
      enable <= next_enable;
      o_irq <= next_irq;
      o_irq_status <= next_status;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Regulator setting and gating mode
  logic [VCODE_W-1:0] next_vcode;
  logic next_gating;

  // Out-of-range codes are ignored, code is kept
  always_comb begin
    next_vcode = o_regulator_voltage_code;
    if (i_vcode_write && i_regulator_voltage_code <= VCODE_MAX) begin
      next_vcode = i_regulator_voltage_code; // [RL8]
    end
    next_gating = o_sleep_gating_on;
    if (i_gating_write) begin
      next_gating = i_sleep_gating_on; // [RL11]
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_regulator_voltage_code <= VCODE_RESET; // [RL9]
      o_sleep_gating_on <= 1'b0; // [RL11]
    end else if (i_ce) begin
      o_regulator_voltage_code <= next_vcode; // [RL10]
      o_sleep_gating_on <= next_gating;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-peripheral deep-sleep gates
  logic [NUM_PERIPH-1:0] next_clk_en;
  logic [NUM_PERIPH-1:0] ds_held;

  for (genvar g = 0; g < NUM_PERIPH; g++) begin : gen_gate
    periph_gate u_gate (
      .i_mclk(i_mclk),
      .i_rst_n(rst_n),
      .i_ce(i_ce),
      .i_ds_set(i_ds_enable && i_peripheral_select == 5'(g)), // [RL15]
      .i_ds_clr(i_ds_disable && i_peripheral_select == 5'(g)),
      .i_run_en(i_run_enable[g]),
      .i_gating_on(o_sleep_gating_on), // [RL11]
      .i_deep_sleep(i_deep_sleep),
      .o_ds_en(ds_held[g]),
      .o_clk_en(next_clk_en[g])
    );
  end

  // Register the clock enables and held settings
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_periph_clk_en <= '0;
      o_ds_enable <= '0;
    end else if (i_ce) begin
      o_periph_clk_en <= next_clk_en; // [RL12] [RL13]
      o_ds_enable <= ds_held; // [RL14]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence clr_cmd_s(int b);
    i_ce && i_irq_cmd.irq_clear && i_irq_cmd.irq_source_mask[b] && !ev_pulse[b];
  endsequence

  clear_drops_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL2]
    clr_cmd_s(0) |=> !raw[0])
    else $error("cleared source still latched");

  irq_or_masked_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL3]
    o_irq == |(raw & enable))
    else $error("irq does not match masked sources");

  enable_set_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL4]
    i_ce && i_irq_cmd.irq_enable_set && !i_irq_cmd.irq_enable_clr
    |=> (enable & $past(i_irq_cmd.irq_source_mask)) == $past(i_irq_cmd.irq_source_mask))
    else $error("enable set missing");

  enable_keep_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL5]
    i_ce && i_irq_cmd.irq_enable_clr && !i_irq_cmd.irq_enable_set
    |=> enable == ($past(enable) & ~$past(i_irq_cmd.irq_source_mask)))
    else $error("enable clear disturbed other bits");

  status_view_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL6]
    i_ce && !i_masked_view_select |=> o_irq_status == raw)
    else $error("raw view wrong");

  event_latch_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL17]
    i_ce && ev_pulse[3] |=> raw[3] && o_irq_status[3] == 1'b1 || $past(i_masked_view_select))
    else $error("event not latched");

  vcode_range_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL8]
    o_regulator_voltage_code <= VCODE_MAX)
    else $error("regulator code out of range");

  gating_off_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL11]
    i_ce && !o_sleep_gating_on |=> o_periph_clk_en == $past(i_run_enable))
    else $error("gating off but clock differs from run");

  ds_stop_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL12]
    i_ce && o_sleep_gating_on && i_deep_sleep && !ds_held[0] |=> !o_periph_clk_en[0])
    else $error("clock not stopped in deep-sleep");

  // Event and clear of one source in the same cycle
  sequence ev_clr_race_s(int b);
    i_ce && ev_pulse[b] && i_irq_cmd.irq_clear && i_irq_cmd.irq_source_mask[b];
  endsequence

  set_wins_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL17]
    ev_clr_race_s(3) |=> raw[3])
    else $error("clear beat a same-cycle event");

  ce_freeze_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL17]
    !i_ce |=> $stable(raw) && $stable(enable) && $stable(o_regulator_voltage_code))
    else $error("state moved while clock enable low");

  clr_wins_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL5]
    i_ce && i_irq_cmd.irq_enable_set && i_irq_cmd.irq_enable_clr
    |=> (enable & $past(i_irq_cmd.irq_source_mask)) == '0)
    else $error("enable clear did not win over set");

  enable_hold_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL4]
    i_ce && !i_irq_cmd.irq_enable_set && !i_irq_cmd.irq_enable_clr |=> $stable(enable))
    else $error("enable changed without access");

  vcode_write_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL8]
    i_ce && i_vcode_write && i_regulator_voltage_code <= VCODE_MAX
    |=> o_regulator_voltage_code == $past(i_regulator_voltage_code))
    else $error("regulator code write lost");

  vcode_hold_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL10]
    i_ce && !i_vcode_write |=> $stable(o_regulator_voltage_code))
    else $error("regulator code changed without write");

  masked_view_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL6]
    i_ce && i_masked_view_select |=> o_irq_status == (raw & enable))
    else $error("masked view wrong");

  ds_resume_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL13]
    i_ce && !i_deep_sleep |=> o_periph_clk_en == $past(i_run_enable))
    else $error("clock not resumed outside deep-sleep");

  ds_retain_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL14]
    i_ce && !i_ds_enable && !i_ds_disable |=> ds_held == $past(ds_held))
    else $error("deep-sleep enable not retained");

  gating_hold_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // [RL11]
    i_ce && !i_gating_write |=> $stable(o_sleep_gating_on))
    else $error("gating mode changed without write");

endmodule // sysctl_irq_and_sleep_gating
`default_nettype wire

// ==== cpu_side_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far side: processor interrupt input and one peripheral's clock
module cpu_side_model (
  input wire logic i_mclk, // System clock
  input wire logic i_resetn, // Reset, active low
  input wire logic i_irq, // Interrupt request
  input wire logic i_clk_en, // Peripheral clock enable
  output logic [7:0] o_irq_entries, // Handler entries
  output logic [15:0] o_ticks // Clocked peripheral cycles
);
  logic irq_q;
  // Count handler entries and the cycles that the peripheral is clocked
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_q <= 1'b0;
      o_irq_entries <= 8'h00;
      o_ticks <= 16'h0000;
    end else begin
      irq_q <= i_irq;
      if (i_irq && !irq_q) o_irq_entries <= o_irq_entries + 8'h01;
      if (i_clk_en) o_ticks <= o_ticks + 16'h0001;
    end
  end
endmodule // cpu_side_model
`default_nettype wire

// ==== sysctl_irq_and_sleep_gating_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module sysctl_irq_and_sleep_gating_bench;
  import sysctl_pkg::*;
  logic i_mclk, i_resetn, msel, vw, gw, gon, dse, dsd, ds, irq, go, ce;
  logic [3:0] ev, vcode, st, vo;
  logic [4:0] psel;
  logic [28:0] run, dso, cen;
  logic [7:0] entries;
  logic [15:0] ticks, t0;
  irq_cmd_s cmd;
  int failures, cmp_count;
  ////////////////////////////////////////////////////////////////////
  // Design and far side
  sysctl_irq_and_sleep_gating i_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(ce),
    .i_irq_event(ev), .i_irq_cmd(cmd), .i_masked_view_select(msel), .i_vcode_write(vw),
    .i_regulator_voltage_code(vcode), .i_gating_write(gw), .i_sleep_gating_on(gon),
    .i_ds_enable(dse), .i_ds_disable(dsd), .i_peripheral_select(psel), .i_run_enable(run),
    .i_deep_sleep(ds), .o_irq(irq), .o_irq_status(st), .o_regulator_voltage_code(vo),
    .o_sleep_gating_on(go), .o_ds_enable(dso), .o_periph_clk_en(cen));
  cpu_side_model i_cpu (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_irq(irq),
    .i_clk_en(cen[0]), .o_irq_entries(entries), .o_ticks(ticks));
  ////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic conclude();
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic send_cmd(input logic [2:0] op, input logic [3:0] m);
    cmd <= {op, m};
    tick(1);
    cmd <= '0;
    tick(2);
  endtask
  // Bounded wait for the interrupt level
  task automatic wait_irq(input logic lvl);
    int k;
    for (k = 0; k < 10 && irq !== lvl; k++) tick(1);
    check(irq, lvl);
    if (irq !== lvl) conclude();
  endtask
  ////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_irq();
    ev <= 4'h5;
    tick(5);
    ev <= 4'h0;
    tick(2);
    check(st, 4'h5);
    check(irq, 1'b0);
    send_cmd(3'b100, 4'h2);
    send_cmd(3'b100, 4'h4);
    msel <= 1'b1;
    tick(2);
    check(st, 4'h4);
    wait_irq(1'b1);
    send_cmd(3'b010, 4'h4);
    check(st, 4'h0);
    wait_irq(1'b0);
    send_cmd(3'b100, 4'hF);
    wait_irq(1'b1);
    msel <= 1'b0;
    send_cmd(3'b001, 4'h1); // Handler clears early
    check(st, 4'h4);
    check(irq, 1'b1);
    send_cmd(3'b001, 4'h4);
    check(st, 4'h0);
    check(irq, 1'b0);
    check(entries, 8'h02);
  endtask
  task automatic t_vcode();
    int c;
    for (c = 0; c < 12; c++) begin
      vcode <= 4'(c);
      vw <= 1'b1;
      tick(1);
      vw <= 1'b0;
      tick(2);
      check(vo, (c > 10) ? 4'hA : 4'(c));
    end
  endtask
  // Clock-enable freeze, then a brown-out event racing its own clear
  task automatic t_misc();
    ce <= 1'b0;
    vcode <= 4'h3;
    vw <= 1'b1;
    tick(2);
    vw <= 1'b0;
    ce <= 1'b1;
    tick(2);
    check(vo, 4'hA);
    ev <= 4'h8;
    tick(2);
    cmd <= {3'b001, 4'h8};
    tick(1);
    cmd <= '0;
    ev <= 4'h0;
    tick(2);
    check(st, 4'h8);
    check(irq, 1'b1);
    send_cmd(3'b001, 4'h8);
    check(st, 4'h0);
    check(irq, 1'b0);
  endtask
  task automatic t_gate();
    run <= '1;
    dse <= 1'b1;
    psel <= 5'd3;
    tick(1);
    psel <= 5'd28;
    tick(1);
    psel <= 5'd29;
    tick(1);
    dse <= 1'b0;
    ds <= 1'b1;
    tick(3);
    check(dso, 29'h1000_0008);
    check(cen, 29'h1FFF_FFFF);
    gw <= 1'b1;
    gon <= 1'b1;
    tick(1);
    gw <= 1'b0;
    tick(3);
    check(go, 1'b1);
    check(cen, 29'h1000_0008);
    t0 = ticks;
    tick(4);
    check(ticks, t0);
    ds <= 1'b0;
    tick(3);
    check(cen, 29'h1FFF_FFFF);
    check(ticks > t0, 1'b1);
    dsd <= 1'b1;
    psel <= 5'd28;
    tick(1);
    dsd <= 1'b0;
    tick(3);
    check(dso, 29'h0000_0008);
  endtask
  ////////////////////////////////////////////////////////////////////
  // Clock, reset, sequence and hang limit
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  initial begin
    #3_000_000;
    failures++;
    conclude();
  end
  initial begin
    {i_resetn, msel, vw, gw, gon, dse, dsd, ds} = '0;
    {ev, vcode, psel, run} = '0;
    cmd = '0;
    ce = 1'b1;
    repeat (6) @(posedge i_mclk);
    i_resetn <= 1'b1;
    tick(4);
    check(vo, 4'h5);
    check(go, 1'b0);
    check({irq, st}, 5'h00);
    check(dso, 29'h0);
    t_irq();
    t_vcode();
    t_misc();
    t_gate();
    conclude();
  end
endmodule // sysctl_irq_and_sleep_gating_bench
`default_nettype wire
